// ---- core/fda_consts.svh ----
// Purpose: Constants of the fan drive alarm manager
// Assumes: Included by bare name, guarded against double inclusion
// Notes: Offsets are register numbers, codes are alarm code values
`ifndef FDA_CONSTS_SVH
`define FDA_CONSTS_SVH

// ****************************************
// Holding register numbers
// ****************************************
`define FDA_HR_RESET 8'h00
`define FDA_HR_INPUT_TYPE 8'h0f
`define FDA_HR_SP_A 8'h15
`define FDA_HR_SP_B 8'h1e
`define FDA_HR_SP_C 8'h27
`define FDA_HR_FAN_MODEL 8'h2c
`define FDA_HR_OUT_FUNC 8'h2e
`define FDA_HR_SP_D 8'h32
`define FDA_HR_COMM_TO 8'h38

// ****************************************
// Input register numbers
// ****************************************
`define FDA_IR_FW 8'h00
`define FDA_IR_MODEL 8'h01
`define FDA_IR_PRIM 8'h0a
`define FDA_IR_SEC 8'h11

// ****************************************
// Reset values and command values
// ****************************************
`define FDA_HR_RST 16'h0000
`define FDA_RESET_CMD 16'h0001
`define FDA_OUT_FUNC_ALARM 16'h0001

// ****************************************
// Alarm codes
// ****************************************
`define FDA_P_NONE 8'h00
`define FDA_P_MEM 8'h01
`define FDA_P_SHORT 8'h02
`define FDA_P_SYNC 8'h03
`define FDA_P_POWER 8'h04
`define FDA_S_NONE 8'h00
`define FDA_S_SUPPLY 8'h01
`define FDA_S_BUS_OV 8'h20
`define FDA_S_BUS_UV 8'h21
`define FDA_S_RELAY 8'h22
`define FDA_S_PHASE_U 8'h31
`define FDA_S_PHASE_V 8'h32
`define FDA_S_PHASE_W 8'h33
`define FDA_S_START_OC 8'h34
`define FDA_S_OVERTEMP 8'h71
`define FDA_S_COMM 8'hff

// ****************************************
// Timing and counts
// ****************************************
`define FDA_CLK_NS 10
`define FDA_SEC_NS 1000000000
`define FDA_RESTART_S 5
`define FDA_SYNC_TRIES 4'h5
`define FDA_RATING_MAX 2'h3

`endif

// ---- core/fda_pkg.sv ----
// Purpose: Types of the fan drive alarm manager
// Assumes: Constants come from fda_consts.svh
// Notes: None
package fda_pkg;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_AUTO = 2'b01,
    ST_BLOCK = 2'b10
  } fda_state_e;

  typedef struct packed {
    logic [7:0] prim;
    logic [7:0] sec;
    logic blocking;
  } fda_alarm_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic holding;
    logic [7:0] addr;
    logic [15:0] data;
  } fda_req_s;

  typedef struct packed {
    logic memErr;
    logic shortCirc;
    logic syncLoss;
    logic supplyOut;
    logic busOver;
    logic busUnder;
    logic relayOpen;
    logic [2:0] phaseMissing;
    logic startOverCur;
    logic overTemp;
  } fda_fault_s;

endpackage

// ---- core/fda_sec_timer.sv ----
// Purpose: One-shot timer counting whole seconds
// Assumes: CYC_PER_SEC of at least 2
// Notes: A start pulse reloads it; zero seconds never expires
`timescale 1ns/10ps
`include "fda_consts.svh"
module fda_sec_timer #(
  parameter int CYC_PER_SEC = `FDA_SEC_NS / `FDA_CLK_NS,
  parameter int SEC_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Control
  input wire logic start,
  input wire logic [SEC_W-1:0] seconds,
  output logic expired
);
  localparam int PW = $clog2(CYC_PER_SEC);
  localparam logic [PW-1:0] PRE_LAST = PW'(CYC_PER_SEC - 1);

  logic [PW-1:0] pre;
  logic [PW-1:0] next_pre;
  logic [SEC_W-1:0] left;
  logic [SEC_W-1:0] next_left;
  logic run;
  logic next_run;
  logic next_expired;

  always_comb begin
    next_pre = pre;
    next_left = left;
    next_run = run;
    next_expired = 1'b0;
    if (start) begin
      next_pre = '0;
      next_left = seconds;
      next_run = (seconds != '0);
    end else if (run) begin
      if (pre == PRE_LAST) begin
        next_pre = '0;
        next_left = left - 1'b1;
        if (left == SEC_W'(1)) begin
          next_run = 1'b0;
          next_expired = 1'b1;
        end
      end else begin
        next_pre = pre + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pre <= '0;
      left <= '0;
      run <= 1'b0;
      expired <= 1'b0;
    end else if (ce) begin
      pre <= next_pre;
      left <= next_left;
      run <= next_run;
      expired <= next_expired;
    end
  end
endmodule

// ---- core/fda_alarm_manager.sv ----
// Purpose: Alarm manager of a fan motor drive with decoded register port
// Assumes: Register requests arrive already decoded from the serial link
// Notes: Power stage, PID and LED patterns live elsewhere
`timescale 1ns/10ps
`include "fda_consts.svh"
module fda_alarm_manager #(
  parameter logic [1:0] RATING = 2'h0,
  parameter logic [15:0] FW_VERSION = 16'h0100,  // Arbitrary value
  parameter logic [15:0] MODEL_CODE = 16'h1234,  // Arbitrary value
  parameter logic [15:0] FAN_MODEL = 16'h0001,
  parameter int CYC_PER_SEC = `FDA_SEC_NS / `FDA_CLK_NS,
  parameter logic [15:0] RESTART_S = 16'(`FDA_RESTART_S)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Register access
  input wire fda_pkg::fda_req_s req,
  output logic [15:0] rdData,
  output logic rdValid,
  // Drive status
  input wire fda_pkg::fda_fault_s faults,
  input wire logic motorRunning,
  input wire logic analogZero,
  // Drive control
  output logic motorEnable,
  output logic restartReq,
  output logic alarmOut,
  output logic alarmActive
);
  import fda_pkg::*;

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic isAnalog(input logic [15:0] t);
    isAnalog = (t == 16'h0001) || (t == 16'h0004) || (t == 16'h0007) || (t == 16'h000a);
  endfunction

  function automatic logic isFixed(input logic [15:0] t);
    isFixed = (t == 16'h0002) || (t == 16'h0006) || (t == 16'h0009) || (t == 16'h000c);
  endfunction

  // Setpoint slot of an address, 3'h4 when none
  function automatic logic [2:0] spSlot(input logic [7:0] a);
    case (a)
      `FDA_HR_SP_A: spSlot = 3'h0;
      `FDA_HR_SP_B: spSlot = 3'h1;
      `FDA_HR_SP_C: spSlot = 3'h2;
      `FDA_HR_SP_D: spSlot = 3'h3;
      default: spSlot = 3'h4;
    endcase
  endfunction

  // Highest-priority active fault, blocking ones first
  function automatic fda_alarm_s pickAlarm(input fda_fault_s f, input logic syncBlk,
                                           input logic comm, input logic stopped);
    pickAlarm = '{`FDA_P_NONE, `FDA_S_NONE, 1'b0};
    if (f.memErr) begin
      pickAlarm = '{`FDA_P_MEM, `FDA_S_NONE, 1'b1};
    end else if (f.shortCirc) begin
      pickAlarm = '{`FDA_P_SHORT, `FDA_S_NONE, 1'b1};
    end else if (f.syncLoss && syncBlk) begin
      pickAlarm = '{`FDA_P_SYNC, `FDA_S_NONE, 1'b1};
    end else if (f.phaseMissing[0]) begin
      pickAlarm = '{`FDA_P_POWER, `FDA_S_PHASE_U, 1'b1};
    end else if (f.phaseMissing[1]) begin
      pickAlarm = '{`FDA_P_POWER, `FDA_S_PHASE_V, 1'b1};
    end else if (f.phaseMissing[2]) begin
      pickAlarm = '{`FDA_P_POWER, `FDA_S_PHASE_W, 1'b1};
    end else if (comm) begin
      pickAlarm = '{`FDA_P_POWER, `FDA_S_COMM, 1'b1};
    end else if (f.syncLoss) begin
      pickAlarm = '{`FDA_P_SYNC, `FDA_S_NONE, 1'b0};
    end else if (f.supplyOut && stopped) begin
      pickAlarm = '{`FDA_P_POWER, `FDA_S_SUPPLY, 1'b0};
    end else if (f.busOver) begin
      pickAlarm = '{`FDA_P_POWER, `FDA_S_BUS_OV, 1'b0};
    end else if (f.busUnder) begin
      pickAlarm = '{`FDA_P_POWER, `FDA_S_BUS_UV, 1'b0};
    end else if (f.relayOpen) begin
      pickAlarm = '{`FDA_P_POWER, `FDA_S_RELAY, 1'b0};
    end else if (f.startOverCur) begin
      pickAlarm = '{`FDA_P_POWER, `FDA_S_START_OC, 1'b0};
    end else if (f.overTemp) begin
      pickAlarm = '{`FDA_P_POWER, `FDA_S_OVERTEMP, 1'b0};
    end
  endfunction

  // ****************************************
  // Holding registers
  // ****************************************
  logic [15:0] resetReg;
  logic [15:0] next_resetReg;
  logic [15:0] inputType;
  logic [15:0] next_inputType;
  logic [15:0] outFunc;
  logic [15:0] next_outFunc;
  logic [15:0] commTo;
  logic [15:0] next_commTo;
  logic [15:0] sp [4];
  logic [15:0] next_sp [4];
  logic [15:0] next_rdData;
  logic next_rdValid;
  logic commKick;
  logic next_commKick;
  logic fixedClr;
  logic [2:0] wrSlot;
  logic [2:0] rdSlot;
  logic [15:0] restWithWr [4];
  fda_alarm_s cur;

  assign wrSlot = spSlot(req.addr);
  assign rdSlot = spSlot(req.addr);

  always_comb begin
    next_resetReg = resetReg;
    next_inputType = inputType;
    next_outFunc = outFunc;
    next_commTo = commTo;
    next_sp = sp;
    restWithWr = sp;
    fixedClr = 1'b0;
    // Reset command is one-shot and reads back as zero afterwards
    if (resetReg == `FDA_RESET_CMD) begin
      next_resetReg = `FDA_HR_RST;
    end
    if (req.wr && req.holding) begin
      case (req.addr)
        `FDA_HR_RESET: next_resetReg = req.data;
        `FDA_HR_INPUT_TYPE: next_inputType = req.data;
        `FDA_HR_OUT_FUNC: next_outFunc = req.data;
        `FDA_HR_COMM_TO: next_commTo = req.data;
        default: next_resetReg = next_resetReg;
      endcase
      if (wrSlot != 3'h4) begin
        next_sp[wrSlot[1:0]] = req.data;
        restWithWr[wrSlot[1:0]] = req.data;
        // Clear only on the write that leaves all four at zero
        fixedClr = isFixed(inputType) && (req.data == 16'h0000) &&
                   (restWithWr[0] == 16'h0000) && (restWithWr[1] == 16'h0000) &&
                   (restWithWr[2] == 16'h0000) && (restWithWr[3] == 16'h0000);
      end
    end
    next_commKick = req.wr || req.rd;
  end

  // ****************************************
  // Read port
  // ****************************************
  always_comb begin
    next_rdValid = req.rd;
    next_rdData = 16'h0000;
    if (req.rd && req.holding) begin
      case (req.addr)
        `FDA_HR_RESET: next_rdData = resetReg;
        `FDA_HR_INPUT_TYPE: next_rdData = inputType;
        `FDA_HR_OUT_FUNC: next_rdData = outFunc;
        `FDA_HR_COMM_TO: next_rdData = commTo;
        `FDA_HR_FAN_MODEL: next_rdData = FAN_MODEL;
        default: next_rdData = (rdSlot != 3'h4) ? sp[rdSlot[1:0]] : 16'h0000;
      endcase
    end else if (req.rd) begin
      case (req.addr)
        `FDA_IR_FW: next_rdData = FW_VERSION;
        `FDA_IR_MODEL: next_rdData = MODEL_CODE;
        `FDA_IR_PRIM: next_rdData = {8'h00, cur.prim};
        `FDA_IR_SEC: next_rdData = {8'h00, cur.sec};
        default: next_rdData = 16'h0000;
      endcase
    end
  end

  // ****************************************
  // Alarm state machine
  // ****************************************
  fda_state_e state;
  fda_state_e next_state;
  fda_alarm_s next_cur;
  fda_alarm_s found;
  logic [3:0] syncTries;
  logic [3:0] next_syncTries;
  logic commLost;
  logic next_commLost;
  logic next_motorEnable;
  logic next_restartReq;
  logic next_alarmOut;
  logic restartStart;
  logic next_restartStart;
  logic restartDone;
  logic commExpired;
  logic clearReq;
  logic syncBlk;

  // Retry budget only exists on the largest rating
  assign syncBlk = (RATING == `FDA_RATING_MAX) && (syncTries >= `FDA_SYNC_TRIES);
  assign clearReq = (resetReg == `FDA_RESET_CMD) ||
                    (isAnalog(inputType) && analogZero) ||
                    fixedClr;
  assign found = pickAlarm(faults, syncBlk, commLost, !motorRunning);

  always_comb begin
    next_state = state;
    next_cur = cur;
    next_syncTries = syncTries;
    next_restartReq = 1'b0;
    next_restartStart = 1'b0;
    // Expiry wins over a same-cycle clear so the loss is never missed
    next_commLost = commExpired ? 1'b1 : (clearReq ? 1'b0 : commLost);
    case (state)
      ST_RUN: begin
        if (found.prim != `FDA_P_NONE) begin
          next_cur = found;
          next_state = found.blocking ? ST_BLOCK : ST_AUTO;
          next_restartStart = !found.blocking;
        end
      end
      ST_AUTO: begin
        if (found.blocking) begin
          next_cur = found;
          next_state = ST_BLOCK;
        end else if (clearReq) begin
          next_cur = '{`FDA_P_NONE, `FDA_S_NONE, 1'b0};
          next_state = ST_RUN;
          next_syncTries = 4'h0;
        end else if ((cur.sec == `FDA_S_OVERTEMP) && !faults.overTemp) begin
          next_cur = '{`FDA_P_NONE, `FDA_S_NONE, 1'b0};
          next_state = ST_RUN;
          next_restartReq = 1'b1;
        end else if (restartDone) begin
          next_cur = '{`FDA_P_NONE, `FDA_S_NONE, 1'b0};
          next_state = ST_RUN;
          next_restartReq = 1'b1;
          if (cur.prim == `FDA_P_SYNC && syncTries != 4'hf) begin
            next_syncTries = syncTries + 4'h1;
          end
        end
      end
      ST_BLOCK: begin
        if (clearReq) begin
          next_cur = '{`FDA_P_NONE, `FDA_S_NONE, 1'b0};
          next_state = ST_RUN;
          next_syncTries = 4'h0;
          next_commLost = commExpired;
        end
      end
      default: begin
        next_state = ST_BLOCK;
      end
    endcase
    next_motorEnable = (next_state == ST_RUN);
    next_alarmOut = (outFunc == `FDA_OUT_FUNC_ALARM) && (next_state != ST_RUN);
  end

  // ****************************************
  // Timers
  // ****************************************
  fda_sec_timer #(
    .CYC_PER_SEC(CYC_PER_SEC),
    .SEC_W(16)
  ) restartTimer (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .start(restartStart),
    .seconds(RESTART_S),
    .expired(restartDone)
  );

  // Any register traffic rearms; zero seconds keeps it idle
  fda_sec_timer #(
    .CYC_PER_SEC(CYC_PER_SEC),
    .SEC_W(16)
  ) commTimer (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .start(commKick),
    .seconds(commTo),
    .expired(commExpired)
  );

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      resetReg <= `FDA_HR_RST;
      inputType <= `FDA_HR_RST;
      outFunc <= `FDA_HR_RST;
      commTo <= `FDA_HR_RST;
      sp <= '{default: `FDA_HR_RST};
      commKick <= 1'b0;
      rdData <= 16'h0000;
      rdValid <= 1'b0;
      state <= ST_RUN;
      cur <= '{`FDA_P_NONE, `FDA_S_NONE, 1'b0};
      syncTries <= 4'h0;
      commLost <= 1'b0;
      motorEnable <= 1'b0;
      restartReq <= 1'b0;
      restartStart <= 1'b0;
      alarmOut <= 1'b0;
      alarmActive <= 1'b0;
    end else if (ce) begin
      resetReg <= next_resetReg;
      inputType <= next_inputType;
      outFunc <= next_outFunc;
      commTo <= next_commTo;
      sp <= next_sp;
      commKick <= next_commKick;
      rdData <= next_rdData;
      rdValid <= next_rdValid;
      state <= next_state;
      cur <= next_cur;
      syncTries <= next_syncTries;
      commLost <= next_commLost;
      motorEnable <= next_motorEnable;
      restartReq <= next_restartReq;
      restartStart <= next_restartStart;
      alarmOut <= next_alarmOut;
      alarmActive <= (next_state != ST_RUN);
    end
  end
endmodule

// ---- bench/fda_alarm_monitor.sv ----
// Purpose: Port-level checks on the alarm manager
// Assumes: Bench keeps ce high apart from one four-cycle freeze near the end
// Notes: Bound to every fda_alarm_manager instance
`timescale 1ns/10ps
module fda_alarm_monitor #(
  parameter int CYC_PER_SEC = 10,
  parameter logic [15:0] RESTART_S = 16'h0002
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Register access
  input wire fda_pkg::fda_req_s req,
  input wire logic [15:0] rdData,
  input wire logic rdValid,
  // Drive status
  input wire fda_pkg::fda_fault_s faults,
  input wire logic motorRunning,
  input wire logic analogZero,
  // Drive control
  input wire logic motorEnable,
  input wire logic restartReq,
  input wire logic alarmOut,
  input wire logic alarmActive
);
  import fda_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence runIdle;
    ce && motorEnable && !alarmActive;
  endsequence
  sequence tripped;
    !motorEnable && alarmActive;
  endsequence
  AST_READ_ANSWER: assert property (ce && req.rd |=> rdValid)
    else $error("read not answered");
  AST_ANSWER_CAUSE: assert property (rdValid |-> $past(req.rd))
    else $error("answer without read");
  AST_CODE_UPPER: assert property (rdValid && $past(!req.holding && req.addr == 8'h0a)
    |-> rdData[15:8] == 8'h00) else $error("alarm code upper byte set");
  AST_BLOCK_TRIP: assert property (runIdle ##0 (faults.memErr || faults.shortCirc)
    |=> tripped ##0 !restartReq [*8]) else $error("blocking fault not stopping");
  AST_AUTO_TRIP: assert property (runIdle ##0 faults.busOver |=> tripped)
    else $error("auto fault not raising alarm");
  // Overtemperature may clear early on its own, so it is left out here
  AST_RESTART_WAIT: assert property ($rose(alarmActive) && !$past(faults.overTemp)
    |-> !restartReq [*8]) else $error("restart too early");
  AST_RESTART_CLEAN: assert property (restartReq |-> motorEnable && !alarmActive)
    else $error("restart with alarm kept");
  AST_ALARM_OUT: assert property (alarmOut |-> alarmActive)
    else $error("alarm output without alarm");
  AST_ENABLE_DROP: assert property ($fell(motorEnable) |-> alarmActive)
    else $error("motor stopped without alarm");
  AST_SUPPLY_RUN: assert property (runIdle ##0 (motorRunning && faults.supplyOut
    && $countones(faults) == 1) |=> !alarmActive) else $error("supply checked while running");
endmodule

bind fda_alarm_manager fda_alarm_monitor #(.CYC_PER_SEC(CYC_PER_SEC), .RESTART_S(RESTART_S)) mon (
  .clk(clk), .nrst(nrst), .ce(ce), .req(req), .rdData(rdData), .rdValid(rdValid),
  .faults(faults), .motorRunning(motorRunning), .analogZero(analogZero),
  .motorEnable(motorEnable), .restartReq(restartReq), .alarmOut(alarmOut),
  .alarmActive(alarmActive));

// ---- bench/fda_master_model.sv ----
// Purpose: Register master on the far side of the alarm manager
// Assumes: One-cycle strobes, answer one cycle after a read
// Notes: Released address and data lines show inverted values
`timescale 1ns/10ps
module fda_master_model (
  // Clock
  input wire logic clk,
  // Register port
  output fda_pkg::fda_req_s req,
  input wire logic [15:0] rdData,
  input wire logic rdValid
);
  import fda_pkg::*;
  initial req = '0;
  // Zeroing setpoints under a fixed input type or writing the reset command clears alarms
  task automatic writeReg(input logic [7:0] addr, input logic [15:0] data);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, holding: 1'b1, addr: addr, data: data};
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, holding: 1'b0, addr: ~addr, data: ~data};
  endtask
  task automatic readReg(input logic holding, input logic [7:0] addr, output logic [15:0] data);
    data = 'x;
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, holding: holding, addr: addr, data: 16'h0000};
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, holding: ~holding, addr: ~addr, data: 16'hffff};
    repeat (4) begin
      @(posedge clk);
      if (rdValid === 1'b1) begin
        data = rdData;
        break;
      end
    end
  endtask
endmodule

// ---- bench/tb_fan_drive_alarm_manager.sv ----
// Purpose: Self-checking bench of the alarm manager
// Assumes: One second shortened to 10 cycles, restart delay 2 s
// Notes: Largest rating, so sync loss blocks after five restarts
`timescale 1ns/10ps
module tb_fan_drive_alarm_manager;
  import fda_pkg::*;
  localparam logic [15:0] FW = 16'h0a5c;  // Arbitrary value
  localparam logic [15:0] MODEL = 16'h3c21;  // Arbitrary value
  localparam logic [15:0] FAN = 16'h0003;
  logic clk, nrst, ce, motorRunning, analogZero, rdValid;
  logic motorEnable, restartReq, alarmOut, alarmActive;
  logic [15:0] rdData;
  fda_req_s req;
  fda_fault_s faults;
  int errors = 0;
  int checksDone = 0;
  logic [11:0] fv [13] = '{12'h800, 12'h400, 12'h200, 12'h100, 12'h080, 12'h040, 12'h020,
    12'h004, 12'h008, 12'h010, 12'h002, 12'h001, 12'h880};
  logic [7:0] prim [13] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04,
    8'h04, 8'h04, 8'h04, 8'h01};
  logic [7:0] sec [13] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h20, 8'h21, 8'h22, 8'h31, 8'h32,
    8'h33, 8'h34, 8'h71, 8'h00};
  logic [12:0] blk = 13'h1383;
  logic [3:0] types [12] = '{4'h1, 4'h4, 4'h7, 4'ha, 4'h2, 4'h6, 4'h9, 4'hc, 4'h0, 4'h5,
    4'h8, 4'hb};
  logic [7:0] sp [4] = '{8'h15, 8'h1e, 8'h27, 8'h32};

  fda_alarm_manager #(.RATING(2'h3), .FW_VERSION(FW), .MODEL_CODE(MODEL), .FAN_MODEL(FAN),
    .CYC_PER_SEC(10), .RESTART_S(16'h0002)) DUT (
    .clk(clk), .nrst(nrst), .ce(ce), .req(req), .rdData(rdData), .rdValid(rdValid),
    .faults(faults), .motorRunning(motorRunning), .analogZero(analogZero),
    .motorEnable(motorEnable), .restartReq(restartReq), .alarmOut(alarmOut),
    .alarmActive(alarmActive));
  fda_master_model mst (.clk(clk), .req(req), .rdData(rdData), .rdValid(rdValid));

  // ****************************************
  // Checking tasks
  // ****************************************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic checkBit(input string name, input logic seen, input logic exp);
    check(name, {15'h0000, seen}, {15'h0000, exp});
  endtask
  task automatic conclude();
    if (errors == 0 && checksDone > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic rdChk(input string name, input logic h, input logic [7:0] a,
    input logic [15:0] exp);
    logic [15:0] v;
    mst.readReg(h, a, v);
    check(name, v, exp);
    // A read that never got its answer ends the run
    if ($isunknown(v)) begin
      conclude();
    end
  endtask
  // Pulse is seen at the edge after it; bound covers delay plus margin
  task automatic waitRestart();
    int n;
    n = 0;
    while (restartReq !== 1'b1 && n <= 60) begin
      @(posedge clk);
      n++;
    end
    checkBit("restartReq", restartReq, 1'b1);
    if (restartReq !== 1'b1) begin
      conclude();
    end
  endtask
  task automatic clearAll();
    mst.writeReg(8'h00, 16'h0001);
    repeat (2) @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    nrst = 1'b0;
    motorRunning = 1'b0;
    analogZero = 1'b0;
    ce = 1'b1;
    faults = '0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    checkBit("motorEnable", motorEnable, 1'b1);
    rdChk("firmware", 1'b0, 8'h00, FW);
    rdChk("model", 1'b0, 8'h01, MODEL);
    mst.writeReg(8'h2c, 16'h0007);
    rdChk("fanModel", 1'b1, 8'h2c, FAN);
    rdChk("prim", 1'b0, 8'h0a, 16'h0000);
    rdChk("sec", 1'b0, 8'h11, 16'h0000);
    rdChk("unmapped", 1'b0, 8'h05, 16'h0000);
    mst.writeReg(8'h2e, 16'h0001);
    for (int i = 0; i < 13; i++) begin
      faults <= fv[i];
      repeat (2) @(posedge clk);
      checkBit("alarmOut", alarmOut, 1'b1);
      rdChk("prim", 1'b0, 8'h0a, {8'h00, prim[i]});
      rdChk("sec", 1'b0, 8'h11, {8'h00, sec[i]});
      faults <= '0;
      if (i == 11) begin
        repeat (2) @(posedge clk);
        checkBit("tempClear", alarmActive, 1'b0);
      end else if (blk[i]) begin
        repeat (30) @(posedge clk);
        checkBit("blocked", motorEnable, 1'b0);
        clearAll();
        checkBit("cleared", motorEnable, 1'b1);
      end else begin
        waitRestart();
      end
      rdChk("primAfter", 1'b0, 8'h0a, 16'h0000);
      checkBit("alarmOutIdle", alarmOut, 1'b0);
    end
    // Twelve input types, all four analog and all four fixed, against every clearing action
    for (int m = 0; m < 12; m++) begin
      mst.writeReg(8'h0f, {12'h000, types[m]});
      faults <= 12'h400;
      @(posedge clk);
      faults <= '0;
      analogZero <= 1'b1;
      repeat (3) @(posedge clk);
      checkBit("analogClear", alarmActive, m >= 4);
      analogZero <= 1'b0;
      for (int k = 0; k < 4; k++) mst.writeReg(sp[k], 16'h0000);
      repeat (2) @(posedge clk);
      checkBit("fixedClear", alarmActive, m >= 8);
      clearAll();
      checkBit("resetClear", alarmActive, 1'b0);
    end
    for (int s = 0; s < 6; s++) begin
      faults <= 12'h200;
      @(posedge clk);
      faults <= '0;
      if (s < 5) waitRestart();
    end
    repeat (40) @(posedge clk);
    checkBit("syncBlock", motorEnable, 1'b0);
    clearAll();
    motorRunning <= 1'b1;
    faults <= 12'h100;
    repeat (3) @(posedge clk);
    checkBit("supplyRunning", alarmActive, 1'b0);
    faults <= '0;
    motorRunning <= 1'b0;
    mst.writeReg(8'h38, 16'h0002);
    repeat (15) @(posedge clk);
    checkBit("commEarly", alarmActive, 1'b0);
    repeat (15) @(posedge clk);
    checkBit("commStop", motorEnable, 1'b0);
    rdChk("commPrim", 1'b0, 8'h0a, 16'h0004);
    rdChk("commSec", 1'b0, 8'h11, 16'h00ff);
    mst.writeReg(8'h38, 16'h0000);
    clearAll();
    checkBit("commCleared", motorEnable, 1'b1);
    // Clock enable low must hold every state, a fresh fault included
    ce <= 1'b0;
    faults <= 12'h800;
    repeat (4) @(posedge clk);
    checkBit("frozenAlarm", alarmActive, 1'b0);
    checkBit("frozenEnable", motorEnable, 1'b1);
    faults <= '0;
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    checkBit("thawed", alarmActive, 1'b0);
    conclude();
  end
endmodule
